//--- bench/gcp_board.sv
// Board model: straps behind the two general-purpose pins
`timescale 1ns/1ns
module gcp_board #(parameter logic [1:0] STRAP = 2'h2) (
  input  wire logic [1:0] gpioOut,
  input  wire logic [1:0] gpioOe,
  output logic [1:0]      gpioIn
);
  // A released pin settles to its strap resistor, not to the last value
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & STRAP);
endmodule

//--- bench/gcp_chk.sv
// Concurrent checks on the global control pin block
`timescale 1ns/1ns
module gcp_chk
  import gcp_pkg::*;
#(
  parameter int NCH    = CHANNELS,
  parameter int RST_CY = RESET_CYCLES
) (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // Control pins
  input wire logic             resetPinN,
  input wire logic             receiveMatchSelect,
  input wire logic             driverEnable,
  input wire logic             hwLineModeSelectEnable,
  input wire logic             hwLineModeSelect,
  // Register port
  input wire logic             regWr,
  input wire logic [7:0]       regAddr,
  input wire logic [31:0]      regWdata,
  // Results
  input wire logic             deviceReady,
  input wire logic [1:0]       gpioOe,
  input wire logic [NCH-1:0]   rxHighZ,
  input wire logic [NCH-1:0]   rxInt120,
  input wire logic [NCH-1:0]   lineModeT1,
  input wire logic [NCH-1:0]   txDriverOe,
  input wire logic [NCH*3-1:0] rxTermCode
);
  // Counter end, state change and ready flop, plus one edge of margin
  localparam int RDY_MAX = RST_CY + 2;
  logic [1:0] wdLo;
  assign wdLo = regWdata[1:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  hiz_all_a:
    assert property (!receiveMatchSelect |=> &rxHighZ)
    else $error("receivers not all high impedance");
  term_off_a:
    assert property (!receiveMatchSelect |=> !(|rxTermCode || |rxInt120))
    else $error("termination not ignored");
  match_on_a:
    assert property (receiveMatchSelect |=> rxHighZ == '0)
    else $error("receivers high impedance while matching");
  drv_off_a:
    assert property (!driverEnable |=> txDriverOe == '0)
    else $error("driver enabled while pin low");
  drv_on_a:
    assert property (driverEnable && deviceReady && resetPinN |=> &txDriverOe)
    else $error("driver off while pin high");
  hw_mode_a:
    assert property (hwLineModeSelectEnable
      |=> lineModeT1 == {NCH{$past(hwLineModeSelect)}})
    else $error("global line mode not followed");
  gpio_dir_a:
    assert property (regWr && regAddr == REG_GPIO && deviceReady && resetPinN
      ##1 resetPinN |=> gpioOe == $past(wdLo, 2))
    else $error("gpio direction not applied");
  rst_hold_a:
    assert property (!resetPinN |=> !deviceReady)
    else $error("ready during reset pin low");
  rst_done_a:
    assert property ($rose(resetPinN) |-> ##[1:RDY_MAX] deviceReady)
    else $error("reset did not finish in time");
endmodule
bind gcp_global_control gcp_chk #(.NCH(NCH), .RST_CY(RST_CY)) gcp_chk_i (
  .mclk                   (mclk),
  .rst                    (rst),
  .resetPinN              (resetPinN),
  .receiveMatchSelect     (receiveMatchSelect),
  .driverEnable           (driverEnable),
  .hwLineModeSelectEnable (hwLineModeSelectEnable),
  .hwLineModeSelect       (hwLineModeSelect),
  .regWr                  (regWr),
  .regAddr                (regAddr),
  .regWdata               (regWdata),
  .deviceReady            (deviceReady),
  .gpioOe                 (gpioOe),
  .rxHighZ                (rxHighZ),
  .rxInt120               (rxInt120),
  .lineModeT1             (lineModeT1),
  .txDriverOe             (txDriverOe),
  .rxTermCode             (rxTermCode)
);

//--- bench/tb_gcp_global_control.sv
// Testbench for the global control pin block
`timescale 1ns/1ns
module tb_gcp_global_control;
  import gcp_pkg::*;
  logic mclk, rst, resetPinN, receiveMatchSelect, driverEnable;
  logic hwLineModeSelectEnable, hwLineModeSelect, regWr, regRd;
  logic deviceReady;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [1:0]  gpioIn, gpioOut, gpioOe;
  logic [15:0] rxHighZ, rxInt120, lineModeT1, txDriverOe;
  logic [47:0] rxTermCode;
  int num_errors = 0;
  int num_checks = 0;
  // Short reset count keeps the run brief
  gcp_global_control #(.RST_CY(4)) gcp_global_control_i (
    .mclk                   (mclk),
    .rst                    (rst),
    .resetPinN              (resetPinN),
    .receiveMatchSelect     (receiveMatchSelect),
    .driverEnable           (driverEnable),
    .hwLineModeSelectEnable (hwLineModeSelectEnable),
    .hwLineModeSelect       (hwLineModeSelect),
    .gpioIn                 (gpioIn),
    .gpioOut                (gpioOut),
    .gpioOe                 (gpioOe),
    .regAddr                (regAddr),
    .regWdata               (regWdata),
    .regWr                  (regWr),
    .regRd                  (regRd),
    .regRdata               (regRdata),
    .rxHighZ                (rxHighZ),
    .rxTermCode             (rxTermCode),
    .rxInt120               (rxInt120),
    .lineModeT1             (lineModeT1),
    .txDriverOe             (txDriverOe),
    .deviceReady            (deviceReady)
  );
  gcp_board gcp_board_i (
    .gpioOut (gpioOut),
    .gpioOe  (gpioOe),
    .gpioIn  (gpioIn)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(string n, logic [47:0] e, logic [47:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk("regRdata", e, regRdata);
  endtask
  task st;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task ready;
    int n;
    n = 0;
    while (deviceReady !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    #1 chk("deviceReady", 1, deviceReady);
  endtask
  initial begin
    #20000;
    num_errors++;
    $display("[ERR] watchdog expected end seen hang");
    results();
  end
  initial begin
    {rst, resetPinN, receiveMatchSelect, driverEnable} = 4'hf;
    {hwLineModeSelectEnable, hwLineModeSelect, regWr, regRd} = 4'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    ready();
    chk("gpioOe", 2'h0, gpioOe);
    rd(REG_GPIO, 32'h8);
    $display("test reset done");
    wr(REG_CHAN_BASE + 8'h03, 32'h1501);
    st();
    chk("rxHighZ", 16'h0, rxHighZ);
    chk("rxTermCode", 48'ha00, rxTermCode);
    chk("rxInt120", 16'h8, rxInt120);
    chk("lineModeT1", 16'h8, lineModeT1);
    hwLineModeSelect <= 1'b1;
    receiveMatchSelect <= 1'b0;
    st();
    chk("lineModeT1", 16'h8, lineModeT1);
    chk("rxHighZ", 16'hffff, rxHighZ);
    chk("rxTermCode", 48'h0, rxTermCode);
    chk("rxInt120", 16'h0, rxInt120);
    hwLineModeSelectEnable <= 1'b1;
    st();
    chk("lineModeT1", 16'hffff, lineModeT1);
    hwLineModeSelect <= 1'b0;
    driverEnable <= 1'b0;
    st();
    chk("lineModeT1", 16'h0, lineModeT1);
    chk("txDriverOe", 16'h0, txDriverOe);
    rd(REG_CHAN_BASE + 8'h03, 32'h1501);
    driverEnable <= 1'b1;
    st();
    chk("txDriverOe", 16'hffff, txDriverOe);
    $display("test pins done");
    wr(REG_GPIO, 32'h5);
    st();
    chk("gpioOe", 2'h1, gpioOe);
    chk("gpioOut0", 1'b1, gpioOut[0]);
    rd(REG_GPIO, 32'hd);
    rd(8'h20, 32'h0);
    rd(REG_STATUS, 32'h16);
    $display("test gpio done");
    resetPinN <= 1'b0;
    st();
    resetPinN <= 1'b1;
    st();
    chk("deviceReady", 1'b0, deviceReady);
    ready();
    chk("gpioOe", 2'h0, gpioOe);
    rd(REG_CHAN_BASE + 8'h03, 32'h0);
    $display("test reset pin done");
    results();
  end
endmodule

//--- verilog/gcp_global_control.sv
// Global control pins: receive matching, driver enable, line mode, GPIO
`timescale 1ns/1ns
module gcp_global_control
  import gcp_pkg::*;
#(
  parameter int NCH    = CHANNELS,
  parameter int RST_CY = RESET_CYCLES
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Device control pins
  input  wire logic             resetPinN,
  input  wire logic             receiveMatchSelect,
  input  wire logic             driverEnable,
  input  wire logic             hwLineModeSelectEnable,
  input  wire logic             hwLineModeSelect,
  // General-purpose pins
  input  wire logic [1:0]       gpioIn,
  output logic [1:0]            gpioOut,
  output logic [1:0]            gpioOe,
  // Register port
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic [31:0]           regRdata,
  // Per-channel results and device ready
  output logic [NCH-1:0]        rxHighZ,
  output logic [NCH*3-1:0]      rxTermCode,
  output logic [NCH-1:0]        rxInt120,
  output logic [NCH-1:0]        lineModeT1,
  output logic [NCH-1:0]        txDriverOe,
  output logic                  deviceReady
);

  // ----------------------------------------------------------------
  // Internal reset sequencing
  // ----------------------------------------------------------------
  gcp_state_type                state_r;
  logic [RESET_CNT_W-1:0]       rstCnt_r;
  logic                         softRst;

  assign softRst = !resetPinN;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_RESET;
      rstCnt_r <= '0;
    end else if (softRst) begin
      state_r  <= ST_RESET;
      rstCnt_r <= '0;
    end else begin
      case (state_r)
        ST_RESET: begin
          // Takes RST_CY cycles, the full 2 us bound at the default of 200
          if (rstCnt_r == RESET_CNT_W'(RST_CY - 1)) begin
            state_r <= ST_RUN;
          end else begin
            rstCnt_r <= rstCnt_r + 1'b1;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      deviceReady <= 1'b0;
    end else begin
      deviceReady <= (state_r == ST_RUN) && !softRst;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CH_WORD_W-1:0]         chanCfg_r [NCH];
  logic [CH_WORD_W-1:0]         rxCfg_r   [NCH];
  logic [1:0]                   gpioDir_r;
  logic [1:0]                   gpioLvl_r;
  logic                         inReset;

  assign inReset = (state_r != ST_RUN) || softRst;

  // Channel words: low byte line mode, next byte rx termination
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        chanCfg_r[i] <= CH_RESET;
        rxCfg_r[i]   <= CH_RESET;
      end
    end else if (inReset) begin
      for (int i = 0; i < NCH; i++) begin
        chanCfg_r[i] <= CH_RESET;
        rxCfg_r[i]   <= CH_RESET;
      end
    end else if (regWr && regAddr < 8'(NCH)) begin
      chanCfg_r[regAddr[3:0]] <= regWdata[7:0];
      rxCfg_r[regAddr[3:0]]   <= regWdata[15:8];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpioDir_r <= GPIO_DIR_RESET;
      gpioLvl_r <= GPIO_LVL_RESET;
    end else if (inReset) begin
      gpioDir_r <= GPIO_DIR_RESET;
      gpioLvl_r <= GPIO_LVL_RESET;
    end else if (regWr && regAddr == REG_GPIO) begin
      gpioDir_r <= regWdata[GPIO_DIR_LSB +: 2];
      gpioLvl_r <= regWdata[GPIO_LVL_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  function automatic logic [1:0] gpioView(input logic [1:0] dir,
                                          input logic [1:0] lvl,
                                          input logic [1:0] pin);
    logic [1:0] v;
    v = '0;
    for (int k = 0; k < GPIO_PINS; k++) begin
      v[k] = (dir[k] == DIR_OUTPUT) ? lvl[k] : pin[k];
    end
    return v;
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
    end else if (regRd) begin
      if (regAddr < 8'(NCH)) begin
        regRdata <= {16'h0000, rxCfg_r[regAddr[3:0]],
                     chanCfg_r[regAddr[3:0]]};
      end else if (regAddr == REG_GPIO) begin
        regRdata <= {28'h0000000, gpioView(gpioDir_r, gpioLvl_r, gpioIn),
                     gpioDir_r};
      end else if (regAddr == REG_STATUS) begin
        regRdata <= {27'h0000000, deviceReady, receiveMatchSelect,
                     driverEnable, hwLineModeSelectEnable,
                     hwLineModeSelect};
      end else begin
        regRdata <= '0;
      end
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // GPIO pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpioOut <= '0;
      gpioOe  <= '0;
    end else begin
      for (int k = 0; k < GPIO_PINS; k++) begin
        gpioOe[k]  <= !inReset && gpioDir_r[k] == DIR_OUTPUT;
        gpioOut[k] <= gpioLvl_r[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive matching, line mode and drivers per channel
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxHighZ    <= '1;
      rxTermCode <= '0;
      rxInt120   <= '0;
      lineModeT1 <= '0;
      txDriverOe <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!receiveMatchSelect) begin
          rxHighZ[c]          <= 1'b1;
          rxTermCode[c*3 +: 3] <= '0;
          rxInt120[c]         <= 1'b0;
        end else begin
          rxHighZ[c]          <= 1'b0;
          rxTermCode[c*3 +: 3] <=
            rxCfg_r[c][CH_TERM_LSB +: CH_TERM_W];
          rxInt120[c]         <= rxCfg_r[c][CH_R120_BIT];
        end
        if (hwLineModeSelectEnable) begin
          lineModeT1[c] <= hwLineModeSelect;
        end else begin
          lineModeT1[c] <= chanCfg_r[c][CH_MODE_BIT];
        end
        // Only the driver enable is gated; config stays intact
        txDriverOe[c] <= driverEnable && !inReset;
      end
    end
  end

endmodule

//--- verilog/gcp_pkg.sv
// Package for the global control pin block
package gcp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CHANNELS      = 16;
  localparam int GPIO_PINS     = 2;

  // ----------------------------------------------------------------
  // Register indices (word offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CHAN_BASE  = 8'h00; // 0x00..0x0f per channel
  localparam logic [7:0] REG_GPIO       = 8'h10;
  localparam logic [7:0] REG_STATUS     = 8'h11;

  // ----------------------------------------------------------------
  // Channel config fields
  // ----------------------------------------------------------------
  localparam int CH_MODE_BIT    = 0;  // line mode, 0 = E1
  localparam int CH_TERM_LSB    = 0;  // termination code in rx word
  localparam int CH_TERM_W      = 3;
  localparam int CH_R120_BIT    = 4;
  localparam int CH_WORD_W      = 8;
  localparam logic [CH_WORD_W-1:0] CH_RESET = 8'h00;

  // ----------------------------------------------------------------
  // GPIO fields
  // ----------------------------------------------------------------
  localparam int GPIO_DIR_LSB   = 0;
  localparam int GPIO_LVL_LSB   = 2;
  localparam logic [1:0] GPIO_DIR_RESET = 2'h0; // both inputs
  localparam logic [1:0] GPIO_LVL_RESET = 2'h0;
  localparam logic       DIR_OUTPUT     = 1'b1;

  // ----------------------------------------------------------------
  // Reset timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int RESET_MAX_NS   = 2000;
  localparam int RESET_CYCLES   = RESET_MAX_NS * CLK_MHZ / 1000;
  localparam int RESET_CNT_W    = 8;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01
  } gcp_state_type;

endpackage
